// ==== common/mdiom_pkg.sv ====
package mdiom_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_ALIVE = 8'h08;
  localparam logic [7:0] OFS_POLL = 8'h30;
  localparam logic [7:0] OFS_IST = 8'h34;
  localparam logic [7:0] OFS_IMSK = 8'h38;
  localparam logic [7:0] OFS_USR = 8'h80;
  // ==========================================================================
  // Field positions
  localparam int CTL_IDLE = 31;
  localparam int CTL_EN = 30;
  localparam int CTL_PRE = 20;
  localparam int CTL_FLT = 19;
  localparam int CTL_FEN = 18;
  localparam int USR_GO = 31;
  localparam int USR_WR = 30;
  localparam int POLL_EN = 31;
  localparam int IST_USR = 0;
  localparam int IST_FLT = 1;
  localparam int IST_NACK = 2;
  // ==========================================================================
  // Reset and fixed values
  localparam logic [15:0] RATIO_RST = 16'h00ff;
  localparam logic [4:0] HUC_VAL = 5'h01;
  localparam logic [4:0] POLL_REG = 5'h01;
  // ==========================================================================
  // Frame layout, counts hold the bits still to come
  localparam logic [5:0] PRE_LAST = 6'h1f;
  localparam logic [5:0] HDR_LAST = 6'h0d;
  localparam logic [5:0] TA_LAST = 6'h01;
  localparam logic [5:0] DAT_LAST = 6'h0f;
  localparam logic [1:0] SOF = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] STB_FULL = 2'h3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRE = 6'h02,
    ST_HDR = 6'h04,
    ST_TA = 6'h08,
    ST_DAT = 6'h10,
    ST_FIN = 6'h20
  } mdiom_st_t;
endpackage : mdiom_pkg

// ==== core/mdiom_sync.sv ====
`timescale 1ns/1ps
module mdiom_sync (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      meta_ff <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : mdiom_sync

// ==== core/mdiom_mgmt_clock_ratio.sv ====
`timescale 1ns/1ps
module mdiom_mgmt_clock_ratio (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic [15:0] ratio_i,
  output logic mdc_o,
  output logic rise_o,
  output logic fall_o
);
  logic [15:0] cnt_ff;
  logic [15:0] gap_ff;
  logic gap_ok_ff;
  logic [15:0] ratio_q_ff;
  wire [16:0] half = ({1'b0, ratio_i} + 17'h00001) >> 1;
  wire run = (ratio_i != 16'h0000);

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      cnt_ff <= 16'h0000;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff <= 16'h0000;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= (cnt_ff >= ratio_i) ? 16'h0000 : cnt_ff + 16'h0001;
      rise_o <= (cnt_ff == 16'h0000);
      fall_o <= (cnt_ff == half[15:0]);
      mdc_o <= (cnt_ff == 16'h0000) ? 1'b1 : (cnt_ff == half[15:0]) ? 1'b0 : mdc_o;
    end
  end

  // ==========================================================================
  // Checks: period between rising edges, only once the ratio has held still
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      gap_ff <= 16'h0000;
      gap_ok_ff <= 1'b0;
      ratio_q_ff <= 16'h0000;
    end
    else
    begin
      ratio_q_ff <= ratio_i;
      gap_ff <= rise_o ? 16'h0000 : gap_ff + 16'h0001;
      gap_ok_ff <= (ratio_q_ff != ratio_i) ? 1'b0 : (rise_o ? 1'b1 : gap_ok_ff);
    end
  end

  property p_div_period;
    @(posedge clk_i) disable iff (!rst_ni)
    (rise_o && gap_ok_ff && ratio_q_ff == ratio_i) |-> (gap_ff == ratio_i);
  endproperty
  a_div_period: assert property (p_div_period) else $error("Clock period is not ratio plus one");

  property p_div_stop;
    @(posedge clk_i) disable iff (!rst_ni)
    (!run) |=> (!mdc_o && !rise_o && !fall_o);
  endproperty
  a_div_stop: assert property (p_div_stop) else $error("Clock runs with zero ratio");
endmodule : mdiom_mgmt_clock_ratio

// ==== core/mdiom_top.sv ====
`timescale 1ns/1ps
module mdiom_top (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic IRQ_O,
  output logic MDC_O,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O
);
  // ==========================================================================
  // Reset release
  logic rs1_ff;
  logic rs2_ff;
  wire rst_n = rs2_ff;

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end
    else
    begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end

  // ==========================================================================
  // Registers and engine state
  logic en_ff;
  logic pre_off_ff;
  logic fault_ff;
  logic fen_ff;
  logic [15:0] ratio_ff;
  logic [31:0] alive_ff;
  logic pen_ff;
  logic [4:0] pphy_ff;
  logic [2:0] ist_ff;
  logic [2:0] imsk_ff;
  logic go_ff;
  logic uwr_ff;
  logic uack_ff;
  logic [4:0] ureg_ff;
  logic [4:0] uphy_ff;
  logic [15:0] udata_ff;
  mdiom_pkg::mdiom_st_t st_ff;
  mdiom_pkg::mdiom_st_t nxt_st;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic [15:0] rdd_ff;
  logic [15:0] nxt_rdd;
  logic ack_ff;
  logic nxt_ack;
  logic usr_ff;
  logic nxt_usr;
  logic rd_ff;
  logic nxt_rd;
  logic [4:0] phy_ff;
  logic [4:0] nxt_phy;
  logic nxt_mdo;
  logic nxt_oe;
  logic [1:0] stb_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic rctl_ff;
  logic mdc_w;
  logic rise;
  logic fall;
  logic mdi;
  wire [2:0] ist_set;

  mdiom_mgmt_clock_ratio u_div (
    .clk_i(CLK_I),
    .rst_ni(rst_n),
    .ratio_i(ratio_ff),
    .mdc_o(mdc_w),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Pin is asynchronous to us, so it passes two flops first
  mdiom_sync u_sync (
    .clk_i(CLK_I),
    .rst_ni(rst_n),
    .d_i(MDIO_I),
    .q_o(mdi)
  );

  // ==========================================================================
  // Bus decode
  wire idle = (st_ff == mdiom_pkg::ST_IDLE);
  wire [31:0] bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wd_m = wdata_ff & bmask;
  wire wr_fire = aw_got_ff && w_got_ff && !BVALID_O;
  wire wr_ctl = wr_fire && (waddr_ff == mdiom_pkg::OFS_CTRL);
  wire wr_alive = wr_fire && (waddr_ff == mdiom_pkg::OFS_ALIVE);
  wire wr_poll = wr_fire && (waddr_ff == mdiom_pkg::OFS_POLL);
  wire wr_ist = wr_fire && (waddr_ff == mdiom_pkg::OFS_IST);
  wire wr_imsk = wr_fire && (waddr_ff == mdiom_pkg::OFS_IMSK);
  wire wr_usr = wr_fire && (waddr_ff == mdiom_pkg::OFS_USR);
  wire wr_hit = wr_ctl || wr_alive || wr_poll || wr_ist || wr_imsk || wr_usr;
  wire [31:0] ctl_rd = {idle, en_ff, 1'b0, mdiom_pkg::HUC_VAL, 3'h0, pre_off_ff,
                        fault_ff, fen_ff, 2'h0, ratio_ff};
  wire [31:0] ctl_new = (ctl_rd & ~bmask) | wd_m;
  wire [31:0] usr_rd = {go_ff, uwr_ff, uack_ff, 3'h0, ureg_ff, uphy_ff, udata_ff};
  wire [31:0] poll_rd = {pen_ff, 26'h0, pphy_ff};
  wire ar_fire = ARVALID_I && ARREADY_O;
  wire r_ctl = (ARADDR_I == mdiom_pkg::OFS_CTRL);
  wire r_alive = (ARADDR_I == mdiom_pkg::OFS_ALIVE);
  wire r_poll = (ARADDR_I == mdiom_pkg::OFS_POLL);
  wire r_ist = (ARADDR_I == mdiom_pkg::OFS_IST);
  wire r_imsk = (ARADDR_I == mdiom_pkg::OFS_IMSK);
  wire r_usr = (ARADDR_I == mdiom_pkg::OFS_USR);
  wire r_hit = r_ctl || r_alive || r_poll || r_ist || r_imsk || r_usr;
  wire [31:0] rd_word = r_ctl ? ctl_rd :
                        r_alive ? alive_ff :
                        r_poll ? poll_rd :
                        r_ist ? {29'h0, ist_ff} :
                        r_imsk ? {29'h0, imsk_ff} :
                        r_usr ? usr_rd : 32'h0;

  // ==========================================================================
  // Frame engine decode
  wire fin = (st_ff == mdiom_pkg::ST_FIN);
  wire ratio_run = (ratio_ff != 16'h0000);
  wire start = idle && fall && en_ff && ratio_run && (go_ff || pen_ff);
  wire sel_rd = go_ff ? !uwr_ff : 1'b1;
  wire [4:0] sel_phy = go_ff ? uphy_ff : pphy_ff;
  wire [4:0] sel_reg = go_ff ? ureg_ff : mdiom_pkg::POLL_REG;
  wire [1:0] sel_op = sel_rd ? mdiom_pkg::OP_RD : mdiom_pkg::OP_WR;
  wire [13:0] hdr = {mdiom_pkg::SOF, sel_op, sel_phy, sel_reg};
  // Compare only once the driven level has settled through the synchroniser
  wire fault_hit = fen_ff && MDIO_OE_O && (stb_ff == mdiom_pkg::STB_FULL) && (mdi != MDIO_O);
  wire ack_upd = fin && rd_ff;
  wire usr_ok = wr_usr && wd_m[mdiom_pkg::USR_GO] && !go_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rdd = rdd_ff;
    nxt_ack = ack_ff;
    nxt_usr = usr_ff;
    nxt_rd = rd_ff;
    nxt_phy = phy_ff;
    nxt_mdo = MDIO_O;
    nxt_oe = MDIO_OE_O;
    case (st_ff)
      mdiom_pkg::ST_IDLE:
      begin
        if (start)
        begin
          nxt_usr = go_ff;
          nxt_rd = sel_rd;
          nxt_phy = sel_phy;
          nxt_ack = 1'b0;
          nxt_oe = 1'b1;
          if (pre_off_ff)
          begin
            nxt_st = mdiom_pkg::ST_HDR;
            nxt_cnt = mdiom_pkg::HDR_LAST;
            nxt_mdo = hdr[13];
            nxt_sh = {hdr[12:0], 3'h0};
          end
          else
          begin
            nxt_st = mdiom_pkg::ST_PRE;
            nxt_cnt = mdiom_pkg::PRE_LAST;
            nxt_mdo = 1'b1;
            nxt_sh = {hdr, 2'h0};
          end
        end
      end
      mdiom_pkg::ST_PRE:
      begin
        if (fall && cnt_ff == 6'h00)
        begin
          nxt_st = mdiom_pkg::ST_HDR;
          nxt_cnt = mdiom_pkg::HDR_LAST;
          nxt_mdo = sh_ff[15];
          nxt_sh = {sh_ff[14:0], 1'b0};
        end
        else if (fall)
        begin
          nxt_cnt = cnt_ff - 6'h01;
        end
      end
      mdiom_pkg::ST_HDR:
      begin
        if (fall && cnt_ff == 6'h00)
        begin
          nxt_st = mdiom_pkg::ST_TA;
          nxt_cnt = mdiom_pkg::TA_LAST;
          nxt_sh = udata_ff;
          nxt_oe = !rd_ff;
          nxt_mdo = 1'b1;
        end
        else if (fall)
        begin
          nxt_cnt = cnt_ff - 6'h01;
          nxt_mdo = sh_ff[15];
          nxt_sh = {sh_ff[14:0], 1'b0};
        end
      end
      mdiom_pkg::ST_TA:
      begin
        if (rise && cnt_ff == 6'h00 && rd_ff)
        begin
          nxt_ack = !mdi;
        end
        if (fall && cnt_ff != 6'h00)
        begin
          nxt_cnt = 6'h00;
          nxt_mdo = 1'b0;
        end
        else if (fall)
        begin
          nxt_st = mdiom_pkg::ST_DAT;
          nxt_cnt = mdiom_pkg::DAT_LAST;
          nxt_mdo = sh_ff[15];
          nxt_sh = {sh_ff[14:0], 1'b0};
        end
      end
      mdiom_pkg::ST_DAT:
      begin
        if (rise && rd_ff)
        begin
          nxt_rdd = {rdd_ff[14:0], mdi};
        end
        if (fall && cnt_ff == 6'h00)
        begin
          nxt_st = mdiom_pkg::ST_FIN;
          nxt_oe = 1'b0;
          nxt_mdo = 1'b0;
        end
        else if (fall)
        begin
          nxt_cnt = cnt_ff - 6'h01;
          nxt_mdo = sh_ff[15];
          nxt_sh = {sh_ff[14:0], 1'b0};
        end
      end
      mdiom_pkg::ST_FIN:
      begin
        nxt_st = mdiom_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_st = mdiom_pkg::ST_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
    if (fault_hit)
    begin
      nxt_st = mdiom_pkg::ST_IDLE;
      nxt_oe = 1'b0;
      nxt_mdo = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= mdiom_pkg::ST_IDLE;
      cnt_ff <= 6'h00;
      sh_ff <= 16'h0000;
      rdd_ff <= 16'h0000;
      ack_ff <= 1'b0;
      usr_ff <= 1'b0;
      rd_ff <= 1'b0;
      phy_ff <= 5'h00;
      MDIO_O <= 1'b0;
      MDIO_OE_O <= 1'b0;
      MDC_O <= 1'b0;
      stb_ff <= 2'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rdd_ff <= nxt_rdd;
      ack_ff <= nxt_ack;
      usr_ff <= nxt_usr;
      rd_ff <= nxt_rd;
      phy_ff <= nxt_phy;
      MDIO_O <= nxt_mdo;
      MDIO_OE_O <= nxt_oe;
      MDC_O <= mdc_w;
      stb_ff <= (nxt_mdo != MDIO_O || nxt_oe != MDIO_OE_O) ? 2'h0 :
                (stb_ff == mdiom_pkg::STB_FULL) ? stb_ff : stb_ff + 2'h1;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_ff <= 1'b0;
      pre_off_ff <= 1'b0;
      fen_ff <= 1'b0;
      ratio_ff <= mdiom_pkg::RATIO_RST;
      fault_ff <= 1'b0;
      pen_ff <= 1'b0;
      pphy_ff <= 5'h00;
      imsk_ff <= 3'h0;
      ist_ff <= 3'h0;
    end
    else
    begin
      if (wr_ctl)
      begin
        en_ff <= ctl_new[mdiom_pkg::CTL_EN];
        pre_off_ff <= ctl_new[mdiom_pkg::CTL_PRE];
        fen_ff <= ctl_new[mdiom_pkg::CTL_FEN];
        ratio_ff <= ctl_new[15:0];
      end
      // A mismatch in the clearing cycle keeps the flag set
      fault_ff <= fault_hit || (fault_ff && !(wr_ctl && wd_m[mdiom_pkg::CTL_FLT]));
      if (wr_poll)
      begin
        pen_ff <= wd_m[mdiom_pkg::POLL_EN] | (pen_ff & ~bmask[mdiom_pkg::POLL_EN]);
        pphy_ff <= wd_m[4:0] | (pphy_ff & ~bmask[4:0]);
      end
      if (wr_imsk)
      begin
        imsk_ff <= wd_m[2:0] | (imsk_ff & ~bmask[2:0]);
      end
      ist_ff <= ist_set | (ist_ff & ~(wr_ist ? wd_m[2:0] : 3'h0));
    end
  end

  assign ist_set[mdiom_pkg::IST_USR] = fin && usr_ff;
  assign ist_set[mdiom_pkg::IST_FLT] = fault_hit;
  assign ist_set[mdiom_pkg::IST_NACK] = ack_upd && !ack_ff;

  // User channel: a go written while one is pending is dropped
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      go_ff <= 1'b0;
      uwr_ff <= 1'b0;
      uack_ff <= 1'b0;
      ureg_ff <= 5'h00;
      uphy_ff <= 5'h00;
      udata_ff <= 16'h0000;
    end
    else if (usr_ok)
    begin
      go_ff <= 1'b1;
      uwr_ff <= wd_m[mdiom_pkg::USR_WR];
      ureg_ff <= wd_m[25:21];
      uphy_ff <= wd_m[20:16];
      udata_ff <= wd_m[15:0];
    end
    else if (fin && usr_ff)
    begin
      go_ff <= 1'b0;
      uack_ff <= ack_ff;
      udata_ff <= rd_ff ? rdd_ff : udata_ff;
    end
  end

  // Acknowledge map, one flop per PHY; an update beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_alive
      wire upd = ack_upd && (phy_ff == 5'(gi));
      logic bit_ff;
      always_ff @(posedge CLK_I or negedge rst_n)
      begin
        if (!rst_n)
        begin
          bit_ff <= 1'b0;
        end
        else
        begin
          bit_ff <= upd ? ack_ff : (bit_ff && !(wr_alive && wd_m[gi]));
        end
      end
      assign alive_ff[gi] = bit_ff;
    end
  endgenerate

  // ==========================================================================
  // AXI4-Lite slave
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= mdiom_pkg::RESP_OK;
    end
    else
    begin
      AWREADY_O <= !aw_got_ff && !(AWVALID_I && AWREADY_O);
      WREADY_O <= !w_got_ff && !(WVALID_I && WREADY_O);
      if (AWVALID_I && AWREADY_O)
      begin
        aw_got_ff <= 1'b1;
        waddr_ff <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= WDATA_I;
        wstrb_ff <= WSTRB_I;
      end
      if (wr_fire)
      begin
        BVALID_O <= 1'b1;
        BRESP_O <= wr_hit ? mdiom_pkg::RESP_OK : mdiom_pkg::RESP_ERR;
      end
      else if (BVALID_O && BREADY_I)
      begin
        BVALID_O <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0;
      RRESP_O <= mdiom_pkg::RESP_OK;
      rctl_ff <= 1'b0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= |(ist_ff & imsk_ff);
      if (ar_fire)
      begin
        ARREADY_O <= 1'b0;
        RVALID_O <= 1'b1;
        RDATA_O <= rd_word;
        RRESP_O <= r_hit ? mdiom_pkg::RESP_OK : mdiom_pkg::RESP_ERR;
        rctl_ff <= r_ctl;
      end
      else if (RVALID_O && RREADY_I)
      begin
        RVALID_O <= 1'b0;
      end
      else if (!RVALID_O)
      begin
        ARREADY_O <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  property p_ctl_idle;
    @(posedge CLK_I) disable iff (!rst_n)
    (ar_fire && r_ctl) |=> (RDATA_O[mdiom_pkg::CTL_IDLE] == $past(idle));
  endproperty
  a_ctl_idle: assert property (p_ctl_idle) else $error("Idle bit disagrees with engine");

  property p_stay_off;
    @(posedge CLK_I) disable iff (!rst_n)
    (idle && !en_ff) |=> idle;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("Disabled engine left idle");

  property p_huc;
    @(posedge CLK_I) disable iff (!rst_n)
    (RVALID_O && rctl_ff) |-> (RDATA_O[28:24] == mdiom_pkg::HUC_VAL);
  endproperty
  a_huc: assert property (p_huc) else $error("Highest channel field wrong");

  property p_no_pre;
    @(posedge CLK_I) disable iff (!rst_n)
    (start && pre_off_ff && !fault_hit) |=> (st_ff == mdiom_pkg::ST_HDR);
  endproperty
  a_no_pre: assert property (p_no_pre) else $error("Preamble sent while suppressed");

  property p_fault;
    @(posedge CLK_I) disable iff (!rst_n)
    fault_hit |=> (idle && fault_ff && !MDIO_OE_O);
  endproperty
  a_fault: assert property (p_fault) else $error("Fault did not reset engine");

  property p_fault_hold;
    @(posedge CLK_I) disable iff (!rst_n)
    (fault_ff && !(wr_ctl && wd_m[mdiom_pkg::CTL_FLT])) |=> fault_ff;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("Fault flag lost");

  property p_fault_off;
    @(posedge CLK_I) disable iff (!rst_n)
    (!fen_ff && !fault_ff) |=> !fault_ff;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("Fault flagged while detection off");

  property p_alive;
    @(posedge CLK_I) disable iff (!rst_n)
    ack_upd |=> (alive_ff[$past(phy_ff)] == $past(ack_ff));
  endproperty
  a_alive: assert property (p_alive) else $error("Acknowledge bit not updated");

  property p_pre_len;
    @(posedge CLK_I) disable iff (!rst_n)
    (st_ff == mdiom_pkg::ST_PRE && fall && cnt_ff == 6'h00 && !fault_hit) |=> (MDIO_O == 1'b0);
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("Start of frame not after preamble");

  c_user_done: cover property (@(posedge CLK_I) disable iff (!rst_n) fin && usr_ff);
  c_poll_done: cover property (@(posedge CLK_I) disable iff (!rst_n) fin && !usr_ff);
  c_ack_seen: cover property (@(posedge CLK_I) disable iff (!rst_n) ack_upd && ack_ff);
  c_fault: cover property (@(posedge CLK_I) disable iff (!rst_n) fault_hit);
endmodule : mdiom_top

// ==== verif/mdiom_phy.sv ====
`timescale 1ns/1ps
// ====================
// Responding PHY
module mdiom_phy (
  input wire logic mdc_i,
  input wire logic mdo_i,
  input wire logic oe_i,
  input wire logic [4:0] addr_i,
  output logic drv_o,
  output logic dat_o,
  output logic [15:0] last_o
);
  localparam logic [15:0] RD_DATA = 16'ha55a;
  logic [13:0] sr = '0;
  logic hit = 1'b0;
  int cnt = -1;
  // Header cleared once seen, so a frame is answered only once
  always @(posedge mdc_i)
  begin
    hit <= !oe_i && sr[13:10] == 4'h6 && sr[9:5] == addr_i;
    sr <= oe_i ? {sr[12:0], mdo_i} : '0;
    // Last 16 driven bits, the data of a write frame
    last_o <= oe_i ? {last_o[14:0], mdo_i} : last_o;
  end
  always @(negedge mdc_i)
    cnt <= (cnt >= 0 && cnt < 16) ? cnt + 1 : (hit ? 0 : -1);
  assign drv_o = cnt >= 0;
  assign dat_o = cnt > 0 && RD_DATA[16 - cnt];
endmodule : mdiom_phy

// ==== verif/mdio_master_control_and_ack_bench.sv ====
`timescale 1ns/1ps
// ====================
// Bench
module mdio_master_control_and_ack_bench;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, flt = 1'b0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, v;
  logic [4:0] pa = 5'h05;
  logic [1:0] resp;
  logic seen0;
  wire awr, wrd, bv, arr, rv, irq, mdc, mo, oe, pd, pdat;
  wire [1:0] rr;
  wire [31:0] rdat;
  wire [15:0] pw;
  wire [1:0] br;
  int bad_count = 0, n_checks = 0, pre_n, mdc_n;
  // A released line floats to the pull-up level
  wire pin = flt ? ~mo : oe ? mo : pd ? pdat : 1'b1;
  mdiom_top DUT (.CLK_I(clk), .NRST_I(nrst), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wrd), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara),
    .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre), .IRQ_O(irq),
    .MDC_O(mdc), .MDIO_I(pin), .MDIO_O(mo), .MDIO_OE_O(oe));
  mdiom_phy phy (.mdc_i(mdc), .mdo_i(pin), .oe_i(oe), .addr_i(pa), .drv_o(pd), .dat_o(pdat), .last_o(pw));
  initial
    forever #12.5 clk = ~clk;
  always @(posedge mdc)
  begin
    mdc_n++;
    if (oe && !seen0 && mo) pre_n++;
    else if (oe) seen0 = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd} <= {a, d};
    {awv, wv, bre} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) resp = br;
      if (bv) bre <= 1'b0;
    end
    while (awv || wv || bre);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) {v, resp} = {rdat, rr};
      if (rv) rre <= 1'b0;
    end
    while (arv || rre);
  endtask : rd
  task automatic go();
    wr(mdiom_pkg::OFS_USR, {11'h402, 5'h05, 16'h0000});
  endtask : go
  task automatic wait_go();
    int k;
    k = 0;
    do
    begin
      rd(mdiom_pkg::OFS_USR);
      k++;
    end
    while (v[31] && k < 300);
    `CHK(v[31], 1'b0)
  endtask : wait_go
  task automatic t_frame(input logic ack, input logic pre);
    pre_n = 0;
    seen0 = 1'b0;
    wr(mdiom_pkg::OFS_CTRL, {11'h200, pre, 20'h00007});
    go();
    repeat (12) @(posedge clk);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[31], 1'b0)
    wait_go();
    `CHK(v[29], ack)
    `CHK(v[15:0], ack ? 16'ha55a : 16'hffff)
    `CHK(pre_n, pre ? 0 : 32)
    rd(mdiom_pkg::OFS_ALIVE);
    `CHK(v[5], ack)
  endtask : t_frame
  task automatic t_reset();
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v, 32'h810000ff)
    rd(mdiom_pkg::OFS_ALIVE);
    `CHK(v, 32'h00000000)
    rd(8'h40);
    `CHK(resp, 2'h2)
    wr(8'h40, 32'h00000000);
    `CHK(resp, 2'h2)
  endtask : t_reset
  task automatic t_div();
    wr(mdiom_pkg::OFS_CTRL, 32'h00000000);
    repeat (8) @(posedge clk);
    mdc_n = 0;
    repeat (40) @(posedge clk);
    `CHK(mdc_n, 0)
    wr(mdiom_pkg::OFS_CTRL, 32'h00000003);
    repeat (8) @(posedge clk);
    mdc_n = 0;
    repeat (40) @(posedge clk);
    `CHK(mdc_n, 10)
  endtask : t_div
  task automatic t_ack();
    t_frame(1'b1, 1'b0);
    t_frame(1'b1, 1'b1);
    wr(mdiom_pkg::OFS_ALIVE, 32'h00000000);
    rd(mdiom_pkg::OFS_ALIVE);
    `CHK(v[5], 1'b1)
    pa <= 5'h07;
    t_frame(1'b0, 1'b0);
    pa <= 5'h05;
    t_frame(1'b1, 1'b1);
    wr(mdiom_pkg::OFS_ALIVE, 32'h00000020);
    rd(mdiom_pkg::OFS_ALIVE);
    `CHK(v, 32'h00000000)
    wr(mdiom_pkg::OFS_POLL, 32'h80000005);
    repeat (1200) @(posedge clk);
    wr(mdiom_pkg::OFS_POLL, 32'h00000000);
    repeat (600) @(posedge clk);
    rd(mdiom_pkg::OFS_ALIVE);
    `CHK(v, 32'h00000020)
    wr(mdiom_pkg::OFS_USR, 32'hc0653c96);
    wait_go();
    `CHK(v[29], 1'b0)
    `CHK(pw, 16'h3c96)
  endtask : t_ack
  task automatic t_fault();
    wr(mdiom_pkg::OFS_IMSK, 32'h00000002);
    flt <= 1'b1;
    wr(mdiom_pkg::OFS_CTRL, 32'h40000007);
    go();
    repeat (100) @(posedge clk);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[19], 1'b0)
    wr(mdiom_pkg::OFS_CTRL, 32'h40040007);
    repeat (100) @(posedge clk);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[19], 1'b1)
    `CHK(irq, 1'b1)
    wr(mdiom_pkg::OFS_IMSK, 32'h00000000);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    flt <= 1'b0;
    wait_go();
    wr(mdiom_pkg::OFS_CTRL, 32'h40040007);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[19], 1'b1)
    wr(mdiom_pkg::OFS_CTRL, 32'h400c0007);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[19], 1'b0)
    wr(mdiom_pkg::OFS_IST, 32'h00000007);
    wr(mdiom_pkg::OFS_IMSK, 32'h00000002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
  endtask : t_fault
  task automatic t_halt();
    go();
    repeat (60) @(posedge clk);
    wr(mdiom_pkg::OFS_CTRL, 32'h00000007);
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[31], 1'b0)
    wait_go();
    rd(mdiom_pkg::OFS_CTRL);
    `CHK(v[31], 1'b1)
  endtask : t_halt
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_div();
    t_ack();
    t_fault();
    t_halt();
    summarize();
  end
  initial
  begin
    #2000000;
    bad_count++;
    summarize();
  end
endmodule : mdio_master_control_and_ack_bench
